//--- rtl/flag_cell.v
// one status flag: either sticky until read, or a state with a change-pending bit
// assumes raw is synchronous to core_clk; clear is a one-cycle read strobe
`timescale 1ns/1ps
`default_nettype none

module flag_cell #(
	parameter STICKY = 1'b0
) (
	input wire core_clk,
	input wire rst_b,
	input wire raw,
	input wire extra_change,
	input wire clear,
	output reg value,
	output wire irq
);

	reg pending;

	// ----------------------------------------
	// flag storage
	// ----------------------------------------
	// set beats clear in both modes so an event in the read cycle survives
	always @(posedge core_clk) begin
		if (!rst_b) begin
			value <= 1'b0;
			pending <= 1'b0;
		end else if (STICKY) begin
			if (raw) begin
				value <= 1'b1;
			end else if (clear) begin
				value <= 1'b0;
			end
			pending <= 1'b0;
		end else begin
			value <= raw;
			if ((raw != value) || extra_change) begin
				pending <= 1'b1;
			end else if (clear) begin
				pending <= 1'b0;
			end
		end
	end

	// sticky flags interrupt while set, state flags only while a change is unread
	assign irq = STICKY ? value : pending;

endmodule // flag_cell

`default_nettype wire

//--- rtl/rx_and_rate_conv_error_flags.v
// receiver and rate converter error flags, their interrupt masks and the burst preamble byte
// assumes the serial control port decoder delivers one-cycle read and write strobes on core_clk
// and that all status inputs are already synchronous to core_clk
`timescale 1ns/1ps
`default_nettype none
`include "rx_conv_flags_defs.vh"

module rx_and_rate_conv_error_flags (
	input wire core_clk,
	input wire rst_b,
	// register access from the control port
	input wire [6:0] reg_addr,
	input wire reg_rd,
	input wire reg_wr,
	input wire [7:0] reg_wdata,
	output reg [7:0] reg_rdata,
	// top-level interrupt status register was read
	input wire int_status_read,
	// receiver status
	input wire rx_valid_flag,
	input wire emphasis_on,
	input wire nonpcm_cs_bit1,
	input wire nonpcm_type_change,
	input wire burst_preamble_seen,
	input wire cs_crc_fail,
	input wire input_absent,
	input wire line_code_error,
	input wire pll_locked,
	// burst preamble words
	input wire nonpcm_detected,
	input wire subframe_nonpcm,
	input wire [15:0] second_preamble,
	input wire [15:0] chan_b_first_preamble,
	// rate converter status
	input wire conv_clock_short,
	input wire left_clip,
	input wire right_clip,
	input wire fast_track_mute_hint,
	// interrupt outputs
	output wire rx_irq,
	output wire rate_conv_irq,
	output reg rx_fault_summary,
	output reg rate_conv_fault_summary
);

	// ----------------------------------------
	// address decoding helper
	// ----------------------------------------
	// shared by the read mux, the read-clear strobes and the write decode
	function addr_hit;
		input [6:0] addr;
		input [6:0] target;
		begin
			addr_hit = (addr == target);
		end
	endfunction

	reg [7:0] rx_irq_enable;
	reg [7:0] cv_irq_enable;
	reg [7:0] next_rdata;
	wire rx_read_clear;
	wire cv_read_clear;
	wire [7:0] rx_flags;
	wire [7:0] rx_pend;
	wire [3:0] cv_flags;
	wire [3:0] cv_pend;
	wire [7:0] cv_flags_word;
	wire [7:0] cv_pend_word;
	wire [7:0] preamble_byte;

	// ----------------------------------------
	// read-clear strobes
	// ----------------------------------------
	// a read of a flag register clears its sticky flags and unread changes
	assign rx_read_clear = reg_rd && addr_hit(reg_addr, `ADDR_RECEIVER_ERROR_FLAGS); // [R7] [R9]
	assign cv_read_clear = reg_rd && addr_hit(reg_addr, `ADDR_RATE_CONVERTER_ERROR_FLAGS); // [R13] [R14]

	// ----------------------------------------
	// receiver error flags
	// ----------------------------------------
	// validity mirrors the stream; its change is what can interrupt
	flag_cell #(.STICKY(1'b0)) u_rx_valid (
		.core_clk(core_clk),
		.rst_b(rst_b),
		.raw(rx_valid_flag), // [R3]
		.extra_change(1'b0),
		.clear(rx_read_clear),
		.value(rx_flags[`RX_BIT_VALID]),
		.irq(rx_pend[`RX_BIT_VALID])
	);

	// emphasis holds its state after a read
	flag_cell #(.STICKY(1'b0)) u_rx_emphasis (
		.core_clk(core_clk),
		.rst_b(rst_b),
		.raw(emphasis_on), // [R4]
		.extra_change(1'b0),
		.clear(rx_read_clear),
		.value(rx_flags[`RX_BIT_EMPHASIS]),
		.irq(rx_pend[`RX_BIT_EMPHASIS])
	);

	// a new non-PCM type counts as a change even if the bit stays high
	flag_cell #(.STICKY(1'b0)) u_rx_nonpcm (
		.core_clk(core_clk),
		.rst_b(rst_b),
		.raw(nonpcm_cs_bit1), // [R5]
		.extra_change(nonpcm_type_change), // [R5]
		.clear(rx_read_clear),
		.value(rx_flags[`RX_BIT_NONPCM]),
		.irq(rx_pend[`RX_BIT_NONPCM])
	);

	// preamble kind itself lives in another register
	flag_cell #(.STICKY(1'b0)) u_rx_burst (
		.core_clk(core_clk),
		.rst_b(rst_b),
		.raw(burst_preamble_seen), // [R6]
		.extra_change(1'b0),
		.clear(rx_read_clear),
		.value(rx_flags[`RX_BIT_BURST]),
		.irq(rx_pend[`RX_BIT_BURST])
	);

	// crc failure is an event, so it is latched
	flag_cell #(.STICKY(1'b1)) u_rx_crc (
		.core_clk(core_clk),
		.rst_b(rst_b),
		.raw(cs_crc_fail), // [R7]
		.extra_change(1'b0),
		.clear(rx_read_clear),
		.value(rx_flags[`RX_BIT_CRC]),
		.irq(rx_pend[`RX_BIT_CRC])
	);

	// stream absence is a level
	flag_cell #(.STICKY(1'b0)) u_rx_absent (
		.core_clk(core_clk),
		.rst_b(rst_b),
		.raw(input_absent), // [R8]
		.extra_change(1'b0),
		.clear(rx_read_clear),
		.value(rx_flags[`RX_BIT_ABSENT]),
		.irq(rx_pend[`RX_BIT_ABSENT])
	);

	// biphase or parity errors latch until read
	flag_cell #(.STICKY(1'b1)) u_rx_linecode (
		.core_clk(core_clk),
		.rst_b(rst_b),
		.raw(line_code_error), // [R9]
		.extra_change(1'b0),
		.clear(rx_read_clear),
		.value(rx_flags[`RX_BIT_LINECODE]),
		.irq(rx_pend[`RX_BIT_LINECODE])
	);

	// lock follows the pll both ways
	flag_cell #(.STICKY(1'b0)) u_rx_lock (
		.core_clk(core_clk),
		.rst_b(rst_b),
		.raw(pll_locked), // [R10]
		.extra_change(1'b0),
		.clear(rx_read_clear),
		.value(rx_flags[`RX_BIT_LOCK]),
		.irq(rx_pend[`RX_BIT_LOCK])
	);

	// ----------------------------------------
	// rate converter error flags
	// ----------------------------------------
	// clock shortfall has no mask bit, so it is visible but never interrupts
	flag_cell #(.STICKY(1'b0)) u_cv_short (
		.core_clk(core_clk),
		.rst_b(rst_b),
		.raw(conv_clock_short), // [R12]
		.extra_change(1'b0),
		.clear(cv_read_clear),
		.value(cv_flags[`CV_BIT_SHORT]),
		.irq(cv_pend[`CV_BIT_SHORT])
	);

	// left output clipping latches until read
	flag_cell #(.STICKY(1'b1)) u_cv_left (
		.core_clk(core_clk),
		.rst_b(rst_b),
		.raw(left_clip), // [R13]
		.extra_change(1'b0),
		.clear(cv_read_clear),
		.value(cv_flags[`CV_BIT_LEFT]),
		.irq(cv_pend[`CV_BIT_LEFT])
	);

	// right output clipping latches until read
	flag_cell #(.STICKY(1'b1)) u_cv_right (
		.core_clk(core_clk),
		.rst_b(rst_b),
		.raw(right_clip), // [R14]
		.extra_change(1'b0),
		.clear(cv_read_clear),
		.value(cv_flags[`CV_BIT_RIGHT]),
		.irq(cv_pend[`CV_BIT_RIGHT])
	);

	// hint stays up for the whole fast phase; host may mute meanwhile
	flag_cell #(.STICKY(1'b0)) u_cv_hint (
		.core_clk(core_clk),
		.rst_b(rst_b),
		.raw(fast_track_mute_hint), // [R15] [R16]
		.extra_change(1'b0),
		.clear(cv_read_clear),
		.value(cv_flags[`CV_BIT_HINT]),
		.irq(cv_pend[`CV_BIT_HINT])
	);

	// reserved upper bits are forced to zero
	assign cv_flags_word = {4'h0, cv_flags} & `CV_USED_MASK; // [R20]
	assign cv_pend_word = {4'h0, cv_pend};

	// ----------------------------------------
	// interrupt gating
	// ----------------------------------------
	// only mask bits with a flag behind them can pass anything
	assign rx_irq = |(rx_pend & rx_irq_enable); // [R11]
	assign rate_conv_irq = |(cv_pend_word & cv_irq_enable & `CV_IRQ_MASK); // [R19]

	// summary bits: set wins over the status register read
	always @(posedge core_clk) begin
		if (!rst_b) begin
			rx_fault_summary <= 1'b0;
			rate_conv_fault_summary <= 1'b0;
		end else begin
			if (rx_irq) begin
				rx_fault_summary <= 1'b1; // [R17]
			end else if (int_status_read) begin
				rx_fault_summary <= 1'b0; // [R17]
			end
			if (rate_conv_irq) begin
				rate_conv_fault_summary <= 1'b1; // [R18]
			end else if (int_status_read) begin
				rate_conv_fault_summary <= 1'b0; // [R18]
			end
		end
	end

	// ----------------------------------------
	// burst preamble byte
	// ----------------------------------------
	// the same byte carries channel B data in per-subframe mode
	assign preamble_byte = !nonpcm_detected ? 8'h00 : // [R1]
		subframe_nonpcm ? chan_b_first_preamble[15:8] : // [R2]
		second_preamble[7:0]; // [R1]

	// ----------------------------------------
	// mask registers
	// ----------------------------------------
	// writes to flag and preamble addresses fall through and change nothing
	always @(posedge core_clk) begin
		if (!rst_b) begin
			rx_irq_enable <= `RESET_RX_IRQ_ENABLE;
			cv_irq_enable <= `RESET_CV_IRQ_ENABLE;
		end else if (reg_wr) begin
			if (addr_hit(reg_addr, `ADDR_RECEIVER_ERROR_IRQ_ENABLE)) begin
				rx_irq_enable <= reg_wdata; // [R11]
			end else if (addr_hit(reg_addr, `ADDR_RATE_CONVERTER_IRQ_ENABLE)) begin
				cv_irq_enable <= reg_wdata & `CV_IRQ_MASK; // [R19] [R20]
			end
		end
	end

	// ----------------------------------------
	// read data
	// ----------------------------------------
	// flag words are sampled before this edge's clear takes effect
	always @* begin
		next_rdata = `RESET_READ_DATA;
		if (addr_hit(reg_addr, `ADDR_BURST_SECOND_PREAMBLE_LOW)) begin
			next_rdata = preamble_byte; // [R1] [R2]
		end else if (addr_hit(reg_addr, `ADDR_RECEIVER_ERROR_FLAGS)) begin
			next_rdata = rx_flags; // [R3]
		end else if (addr_hit(reg_addr, `ADDR_RECEIVER_ERROR_IRQ_ENABLE)) begin
			next_rdata = rx_irq_enable;
		end else if (addr_hit(reg_addr, `ADDR_RATE_CONVERTER_ERROR_FLAGS)) begin
			next_rdata = cv_flags_word; // [R20]
		end else if (addr_hit(reg_addr, `ADDR_RATE_CONVERTER_IRQ_ENABLE)) begin
			next_rdata = cv_irq_enable;
		end else begin
			next_rdata = `RESET_READ_DATA; // unmapped reads as zero
		end
	end

	// read data holds until the next read so a slow shifter can take it
	always @(posedge core_clk) begin
		if (!rst_b) begin
			reg_rdata <= `RESET_READ_DATA;
		end else if (reg_rd) begin
			reg_rdata <= next_rdata;
		end
	end

endmodule // rx_and_rate_conv_error_flags

`default_nettype wire

//--- rtl/rx_conv_flags_defs.vh
// register offsets, field positions and reset values of the receiver and rate converter flag block
// assumes a serial control port decoder that hands over 7-bit addresses and byte strobes
//
// Overview of operation
// [R1] preamble byte reads zero unless non-PCM detected
// [R2] subframe non-PCM: byte carries channel B high byte
// [R3] bit 7 mirrors received validity bit
// [R4] emphasis flag follows state, interrupts on change
// [R5] non-PCM flag interrupts on change or type change
// [R6] burst preamble flag interrupts on change only
// [R7] CRC failure sticky until receiver register read
// [R8] input-absent flag interrupts on change only
// [R9] line-code error sticky until register read
// [R10] lock flag follows PLL, interrupts on change
// [R11] per-bit receiver mask, one enables interrupt
// [R12] clock-shortfall flag shows converter clock too slow
// [R13] left clip sticky until converter register read
// [R14] right clip sticky until converter register read
// [R15] mute hint follows fast mode, interrupts on change
// [R16] host may mute output during fast mode
// [R17] receiver summary sticky until status register read
// [R18] converter summary sticky until status register read
// [R19] converter mask bits enable clip and hint
// [R20] reserved bits zero, read-only writes ignored
`ifndef RX_CONV_FLAGS_DEFS_VH
`define RX_CONV_FLAGS_DEFS_VH

// ----------------------------------------
// register offsets (7-bit control port addresses)
// ----------------------------------------
`define ADDR_BURST_SECOND_PREAMBLE_LOW 7'h17
`define ADDR_RECEIVER_ERROR_FLAGS 7'h18
`define ADDR_RECEIVER_ERROR_IRQ_ENABLE 7'h19
`define ADDR_RATE_CONVERTER_ERROR_FLAGS 7'h1a
`define ADDR_RATE_CONVERTER_IRQ_ENABLE 7'h1b

// ----------------------------------------
// receiver error flag positions
// ----------------------------------------
`define RX_BIT_VALID 7
`define RX_BIT_EMPHASIS 6
`define RX_BIT_NONPCM 5
`define RX_BIT_BURST 4
`define RX_BIT_CRC 3
`define RX_BIT_ABSENT 2
`define RX_BIT_LINECODE 1
`define RX_BIT_LOCK 0

// ----------------------------------------
// rate converter error flag positions
// ----------------------------------------
`define CV_BIT_SHORT 3
`define CV_BIT_LEFT 2
`define CV_BIT_RIGHT 1
`define CV_BIT_HINT 0
`define CV_USED_MASK 8'h0f
`define CV_IRQ_MASK 8'h07

// ----------------------------------------
// reset values
// ----------------------------------------
`define RESET_RX_IRQ_ENABLE 8'h00
`define RESET_CV_IRQ_ENABLE 8'h00
`define RESET_READ_DATA 8'h00

`endif

//--- sim/host_port.sv
// host side of the control port: one-cycle read and write strobes
// assumes the flag block answers a read one edge after the strobe
`timescale 1ns/1ps
`default_nettype none
module host_port (
	input wire core_clk,
	input wire [7:0] reg_rdata,
	output logic [6:0] reg_addr,
	output logic reg_rd,
	output logic reg_wr,
	output logic [7:0] reg_wdata
);
	// idle bus shows inverted values so no stale address looks valid
	initial begin
		reg_addr = 7'h7f;
		reg_rd = 1'b0;
		reg_wr = 1'b0;
		reg_wdata = 8'h00;
	end
	// muting the converter during fast mode is optional and left out
	task wr(input logic [6:0] a, input logic [7:0] d);
		@(negedge core_clk);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge core_clk);
		reg_wr = 1'b0;
		reg_addr = ~a;
		reg_wdata = ~d;
	endtask
	// data is registered at the taking edge and sampled half a cycle on
	task rd(input logic [6:0] a, output logic [7:0] d);
		@(negedge core_clk);
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge core_clk);
		d = reg_rdata;
		reg_rd = 1'b0;
		reg_addr = ~a;
	endtask
endmodule // host_port
`default_nettype wire

//--- sim/rx_and_rate_conv_error_flags_bench.sv
// bench of the flag block: register reads and writes with expected bytes
// assumes the defs header is on the include path
`timescale 1ns/1ps
`default_nettype none
`include "rx_conv_flags_defs.vh"
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin bad_count++; \
	$display("wrong value %s expected %h seen %h", n, e, g); end end
module rx_and_rate_conv_error_flags_bench;
	logic core_clk = 0, rst_b = 0, isr = 0, vld = 0, emp = 0, npc = 0, ntc = 0, bst = 0, crc = 0, abs = 0;
	logic lce = 0, pll = 0, nd = 0, sub = 0, csh = 0, lc = 0, rc_ = 0, hint = 0;
	logic [6:0] addr;
	logic rd, wr, rx_irq, cv_irq, rx_sum, cv_sum;
	logic [7:0] wdata, rdata;
	int bad_count = 0, num_checks = 0, cycles = 0;
	always #2 core_clk = ~core_clk;
	host_port h (.core_clk(core_clk), .reg_rdata(rdata), .reg_addr(addr), .reg_rd(rd), .reg_wr(wr),
		.reg_wdata(wdata));
	rx_and_rate_conv_error_flags dut (.core_clk(core_clk), .rst_b(rst_b), .reg_addr(addr), .reg_rd(rd),
		.reg_wr(wr), .reg_wdata(wdata), .reg_rdata(rdata), .int_status_read(isr), .rx_valid_flag(vld),
		.emphasis_on(emp), .nonpcm_cs_bit1(npc), .nonpcm_type_change(ntc), .burst_preamble_seen(bst),
		.cs_crc_fail(crc), .input_absent(abs), .line_code_error(lce), .pll_locked(pll), .nonpcm_detected(nd),
		.subframe_nonpcm(sub), .second_preamble(16'h1234), .chan_b_first_preamble(16'habcd),
		.conv_clock_short(csh), .left_clip(lc), .right_clip(rc_), .fast_track_mute_hint(hint), .rx_irq(rx_irq),
		.rate_conv_irq(cv_irq), .rx_fault_summary(rx_sum), .rate_conv_fault_summary(cv_sum));
	// ----------------
	// tasks
	// ----------------
	task rc(input logic [6:0] a, input logic [7:0] e);
		logic [7:0] d;
		h.rd(a, d);
		`CHK("reg_rdata", e, d)
	endtask
	task final_report;
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	// run takes about 70 cycles; the ceiling leaves ample room
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 3000) begin
			bad_count++;
			final_report;
		end
	end
	// ----------------
	// tests
	// ----------------
	initial begin
		repeat (6) @(negedge core_clk);
		rst_b = 1;
		rc(`ADDR_RECEIVER_ERROR_IRQ_ENABLE, 8'h00);
		rc(`ADDR_RATE_CONVERTER_ERROR_FLAGS, 8'h00);
		rc(7'h30, 8'h00);
		h.wr(`ADDR_RECEIVER_ERROR_IRQ_ENABLE, 8'hff);
		h.wr(`ADDR_RATE_CONVERTER_IRQ_ENABLE, 8'hff);
		h.wr(`ADDR_RECEIVER_ERROR_FLAGS, 8'hff);
		rc(`ADDR_RECEIVER_ERROR_IRQ_ENABLE, 8'hff);
		rc(`ADDR_RATE_CONVERTER_IRQ_ENABLE, 8'h07);
		rc(`ADDR_RECEIVER_ERROR_FLAGS, 8'h00);
		$display("test reset and masks done");
		// sticky pulses, then read clears them
		crc = 1;
		lce = 1;
		@(negedge core_clk);
		{crc, lce} = 2'h0;
		`CHK("rx_irq", 1'b1, rx_irq)
		@(negedge core_clk);
		`CHK("rx_fault_summary", 1'b1, rx_sum)
		rc(`ADDR_RECEIVER_ERROR_FLAGS, 8'h0a);
		rc(`ADDR_RECEIVER_ERROR_FLAGS, 8'h00);
		`CHK("rx_irq", 1'b0, rx_irq)
		`CHK("rx_fault_summary", 1'b1, rx_sum)
		isr = 1;
		@(negedge core_clk);
		isr = 0;
		`CHK("rx_fault_summary", 1'b0, rx_sum)
		$display("test sticky flags done");
		// state flags keep their value after a read
		{vld, emp, npc, bst, abs, pll} = 6'h3f;
		repeat (2) @(negedge core_clk);
		`CHK("rx_irq", 1'b1, rx_irq)
		rc(`ADDR_RECEIVER_ERROR_FLAGS, 8'hf5);
		`CHK("rx_irq", 1'b0, rx_irq)
		rc(`ADDR_RECEIVER_ERROR_FLAGS, 8'hf5);
		pll = 0;
		@(negedge core_clk);
		`CHK("rx_irq", 1'b1, rx_irq)
		rc(`ADDR_RECEIVER_ERROR_FLAGS, 8'hf4);
		ntc = 1;
		@(negedge core_clk);
		ntc = 0;
		`CHK("rx_irq", 1'b1, rx_irq)
		rc(`ADDR_RECEIVER_ERROR_FLAGS, 8'hf4);
		h.wr(`ADDR_RECEIVER_ERROR_IRQ_ENABLE, 8'hf7);
		crc = 1;
		@(negedge core_clk);
		crc = 0;
		`CHK("rx_irq", 1'b0, rx_irq)
		rc(`ADDR_RECEIVER_ERROR_FLAGS, 8'hfc);
		$display("test state flags done");
		// converter flags and their mask
		{csh, lc, rc_, hint} = 4'hf;
		@(negedge core_clk);
		{lc, rc_} = 2'h0;
		`CHK("rate_conv_irq", 1'b1, cv_irq)
		@(negedge core_clk);
		`CHK("rate_conv_fault_summary", 1'b1, cv_sum)
		rc(`ADDR_RATE_CONVERTER_ERROR_FLAGS, 8'h0f);
		rc(`ADDR_RATE_CONVERTER_ERROR_FLAGS, 8'h09);
		`CHK("rate_conv_irq", 1'b0, cv_irq)
		h.wr(`ADDR_RATE_CONVERTER_IRQ_ENABLE, 8'h00);
		hint = 0;
		isr = 1;
		@(negedge core_clk);
		isr = 0;
		`CHK("rate_conv_irq", 1'b0, cv_irq)
		`CHK("rate_conv_fault_summary", 1'b0, cv_sum)
		rc(`ADDR_RATE_CONVERTER_ERROR_FLAGS, 8'h08);
		$display("test converter done");
		// preamble byte in its three modes
		rc(`ADDR_BURST_SECOND_PREAMBLE_LOW, 8'h00);
		nd = 1;
		rc(`ADDR_BURST_SECOND_PREAMBLE_LOW, 8'h34);
		sub = 1;
		rc(`ADDR_BURST_SECOND_PREAMBLE_LOW, 8'hab);
		$display("test preamble done");
		// mid-run reset: held read data, converter summary and receiver mask go back to zero
		rst_b = 0;
		repeat (2) @(negedge core_clk);
		`CHK("reg_rdata", 8'h00, rdata)
		`CHK("rate_conv_fault_summary", 1'b0, cv_sum)
		rst_b = 1;
		rc(`ADDR_RECEIVER_ERROR_IRQ_ENABLE, 8'h00);
		rc(`ADDR_RATE_CONVERTER_ERROR_FLAGS, 8'h08);
		$display("test mid-run reset done");
		final_report;
	end
endmodule // rx_and_rate_conv_error_flags_bench
`default_nettype wire

//--- sim/rx_conv_flags_sva.sv
// checker of the flag block: read data, interrupt gating and summaries
// assumes only the top ports are visible; bound at the foot
`timescale 1ns/1ps
`default_nettype none
module rx_conv_flags_sva (
	input wire core_clk,
	input wire rst_b,
	input wire [6:0] reg_addr,
	input wire reg_rd,
	input wire reg_wr,
	input wire [7:0] reg_wdata,
	input wire [7:0] reg_rdata,
	input wire int_status_read,
	input wire rx_valid_flag,
	input wire cs_crc_fail,
	input wire left_clip,
	input wire nonpcm_detected,
	input wire subframe_nonpcm,
	input wire [15:0] chan_b_first_preamble,
	input wire rx_irq,
	input wire rate_conv_irq,
	input wire rx_fault_summary,
	input wire rate_conv_fault_summary
);
	// ----------------
	// mask shadows
	// ----------------
	logic [7:0] rx_mask;
	logic [2:0] cv_mask;
	// masks are internal, so gating is judged from copies of the writes
	always @(posedge core_clk) begin
		if (!rst_b) begin
			rx_mask <= 8'h00;
			cv_mask <= 3'h0;
		end else if (reg_wr && reg_addr == 7'h19) begin
			rx_mask <= reg_wdata;
		end else if (reg_wr && reg_addr == 7'h1b) begin
			cv_mask <= reg_wdata[2:0];
		end
	end
	// ----------------
	// properties
	// ----------------
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_b);
	chk_unmapped_zero: assert property (reg_rd && (reg_addr < 7'h17 || reg_addr > 7'h1b) |=>
		reg_rdata == 8'h00) else $error("unmapped read not zero");
	chk_preamble_zero: assert property (reg_rd && reg_addr == 7'h17 && !nonpcm_detected |=>
		reg_rdata == 8'h00) else $error("preamble byte not zero");
	chk_preamble_sub: assert property (reg_rd && reg_addr == 7'h17 && nonpcm_detected && subframe_nonpcm
		|=> reg_rdata == $past(chan_b_first_preamble[15:8])) else $error("channel b byte wrong");
	// read returns the flag taken one edge before, hence the stable input
	chk_valid_mirror: assert property (reg_rd && reg_addr == 7'h18 && $past(rst_b) && $stable(rx_valid_flag)
		|=> reg_rdata[7] == $past(rx_valid_flag)) else $error("validity not mirrored");
	chk_rx_mask_block: assert property (rx_mask == 8'h00 |-> !rx_irq) else $error("masked rx irq");
	chk_cv_mask_block: assert property (cv_mask == 3'h0 |-> !rate_conv_irq) else $error("masked cv irq");
	chk_crc_irq: assert property (cs_crc_fail && rx_mask[3] |=> rx_irq) else $error("crc no irq");
	chk_clip_irq: assert property (left_clip && cv_mask[2] |=> rate_conv_irq) else $error("clip no irq");
	chk_rx_summary: assert property (rx_irq |=> rx_fault_summary) else $error("rx summary not set");
	chk_cv_summary_hold: assert property (rate_conv_fault_summary && !int_status_read |=>
		rate_conv_fault_summary) else $error("cv summary dropped");
	cover property (reg_rd && reg_addr == 7'h18 && rx_irq);
	cover property (rate_conv_irq ##1 rate_conv_fault_summary);
	cover property (int_status_read && rx_fault_summary);
endmodule // rx_conv_flags_sva
bind rx_and_rate_conv_error_flags rx_conv_flags_sva chk (.core_clk, .rst_b, .reg_addr, .reg_rd, .reg_wr,
	.reg_wdata, .reg_rdata, .int_status_read, .rx_valid_flag, .cs_crc_fail, .left_clip, .nonpcm_detected,
	.subframe_nonpcm, .chan_b_first_preamble, .rx_irq, .rate_conv_irq, .rx_fault_summary,
	.rate_conv_fault_summary);
`default_nettype wire
